// ===== hw/rcr_pkg.sv
// Constants shared by the reset cause recorder.
// Assumes an 8-bit special function register bus and one 40 MHz system clock.
package rcr_pkg;

    // Register placement
    localparam logic [7:0] RCR_CAUSE_ADDR = 8'hEF;

    // Bit positions of the reset cause register
    localparam int RCR_BIT_USB  = 7;
    localparam int RCR_BIT_MEM  = 6;
    localparam int RCR_BIT_CMP  = 5;
    localparam int RCR_BIT_SW   = 4;
    localparam int RCR_BIT_WDT  = 3;
    localparam int RCR_BIT_MCD  = 2;
    localparam int RCR_BIT_POR  = 1;
    localparam int RCR_BIT_PIN  = 0;

    // Values after reset
    localparam logic [7:0] RCR_FLAGS_POR   = 8'h02;
    localparam logic [7:0] RCR_ENABLES_RST = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS      = 25;
    localparam int RESET_HOLD_NS      = 1000;
    localparam int RESET_HOLD_CYCLES  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLOCK_LOSS_NS      = 500;
    localparam int CLOCK_LOSS_CYCLES  = (CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_PRESCALE       = 12;
    localparam int WDT_LIMIT_TICKS    = 256;

    typedef enum logic [0:0] {
        RCR_RUN  = 1'b0,
        RCR_HOLD = 1'b1
    } rcr_state_type;

endpackage

// ===== hw/rcr_clock_loss.sv
// Clock loss detector: times out when the watched activity level stops changing.
// Assumes clk_activity toggles with the watched clock and is synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module rcr_clock_loss
    import rcr_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = CLOCK_LOSS_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Control
    input  wire logic enable,
    input  wire logic clk_activity,
    // Result
    output logic      timeout
);

    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

    generate
        if (TIMEOUT_CYCLES < 2) begin : g_check
            $error("rcr_clock_loss: TIMEOUT_CYCLES must be at least 2");
        end
    endgenerate

    logic          last_reg;
    logic [CW-1:0] idle_reg;
    logic          timeout_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= clk_activity;
        end
    end

    // Stuck high or stuck low both stop the toggling
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !enable || (clk_activity != last_reg)) begin
            idle_reg    <= '0;
            timeout_reg <= 1'b0;
        end else if (idle_reg == CW'(TIMEOUT_CYCLES - 1)) begin
            timeout_reg <= 1'b1;
        end else begin
            idle_reg    <= idle_reg + CW'(1);
            timeout_reg <= 1'b0;
        end
    end

    assign timeout = timeout_reg;

endmodule
`default_nettype wire

// ===== hw/rcr_reset_cause_recorder.sv
// Reset cause recorder: reset sources, reset hold, cause flags and the watchdog.
// Assumes the 8-bit register port and all source inputs are synchronous to clk_sys;
// sys_rst is the power-on reset.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Bit 7 written 1 enables USB as a reset source and reads 1 after a USB reset.
// - Bit 6 reads 1 after a program memory fault reset and ignores writes.
// - Bit 5 written 1 enables the active-low comparator reset and reads 1 after one.
// - Writing 1 to bit 4 forces a system reset at once.
// - Bit 4 reads 1 only after a software forced reset.
// - Bit 3 reads 1 after a watchdog overflow reset and ignores writes.
// - Bit 2 written 1 enables the clock loss detector and reads 1 after its timeout reset.
// - Bit 1 reads 1 after power-on or supply monitor reset, other flags then being undefined.
// - Bit 0 reads 1 after a reset caused by the external reset pin and ignores writes.
// - Writing 0 to bit 2 disables the detector, which fires when the clock stalls.
// - An enabled comparator holds reset while its non-inverting input is below the other.
// - Enabled USB resets on bus reset signalling or a bus power edge of the chosen polarity.
// - The watchdog runs at the system clock divided by 12 after any reset and resets on a miss.
module rcr_reset_cause_recorder
    import rcr_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
    parameter int WDT_TICKS   = WDT_LIMIT_TICKS
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Reset sources
    input  wire logic       pin_rst_n,
    input  wire logic       cmp_above,
    input  wire logic       vdd_above,
    input  wire logic       clk_activity,
    input  wire logic       usb_bus_reset,
    input  wire logic       vbus_level,
    input  wire logic       vbus_pol_rising,
    input  wire logic       mem_fault,
    // Watchdog control
    input  wire logic       wdt_kick,
    input  wire logic       wdt_stop,
    // Results
    output logic            system_reset,
    output logic            wdt_running
);

    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int PW = $clog2(WDT_PRESCALE);
    localparam int WW = $clog2(WDT_TICKS + 1);

    generate
        if (HOLD_CYCLES < 1 || WDT_TICKS < 2) begin : g_check
            $error("rcr_reset_cause_recorder: HOLD_CYCLES >= 1 and WDT_TICKS >= 2 required");
        end
    endgenerate

    // Highest priority source wins when several fire together
    function automatic logic [7:0] pick_cause(input logic [7:0] req);
        logic [7:0] one;
        one = 8'h00;
        if (req[RCR_BIT_POR])      one[RCR_BIT_POR] = 1'b1;
        else if (req[RCR_BIT_PIN]) one[RCR_BIT_PIN] = 1'b1;
        else if (req[RCR_BIT_MCD]) one[RCR_BIT_MCD] = 1'b1;
        else if (req[RCR_BIT_MEM]) one[RCR_BIT_MEM] = 1'b1;
        else if (req[RCR_BIT_WDT]) one[RCR_BIT_WDT] = 1'b1;
        else if (req[RCR_BIT_CMP]) one[RCR_BIT_CMP] = 1'b1;
        else if (req[RCR_BIT_USB]) one[RCR_BIT_USB] = 1'b1;
        else if (req[RCR_BIT_SW])  one[RCR_BIT_SW]  = 1'b1;
        return one;
    endfunction

    rcr_state_type  state_reg;
    logic [HW-1:0]  hold_reg;
    logic [7:0]     cause_reg;
    logic [7:0]     flags_reg;
    logic [7:0]     enables_reg;
    logic           system_reset_reg;
    logic [7:0]     sfr_rdata_reg;
    logic           vbus_last_reg;
    logic           wdt_run_reg;
    logic [PW-1:0]  wdt_pre_reg;
    logic [WW-1:0]  wdt_cnt_reg;
    logic           wdt_ovf_reg;
    logic           clock_lost;
    logic           cause_write;
    logic           vbus_edge;
    logic           level_hold;
    logic           hold_done;
    logic [7:0]     req;

    assign cause_write = sfr_wr && (sfr_addr == RCR_CAUSE_ADDR) && (state_reg == RCR_RUN);

    assign vbus_edge = (vbus_level != vbus_last_reg) && (vbus_level == vbus_pol_rising);

    // Level sources keep the device in reset for as long as they persist
    assign level_hold = !pin_rst_n
                      || (enables_reg[RCR_BIT_CMP] && !cmp_above)
                      || (enables_reg[RCR_BIT_POR] && !vdd_above);

    assign hold_done = (state_reg == RCR_HOLD) && !level_hold && (hold_reg == '0);

    always_comb begin
        req = 8'h00;
        req[RCR_BIT_POR] = enables_reg[RCR_BIT_POR] && !vdd_above;
        req[RCR_BIT_PIN] = !pin_rst_n;
        req[RCR_BIT_MCD] = clock_lost;
        req[RCR_BIT_MEM] = mem_fault;
        req[RCR_BIT_WDT] = wdt_ovf_reg;
        req[RCR_BIT_CMP] = enables_reg[RCR_BIT_CMP] && !cmp_above;
        req[RCR_BIT_USB] = enables_reg[RCR_BIT_USB] && (usb_bus_reset || vbus_edge);
        req[RCR_BIT_SW]  = cause_write && sfr_wdata[RCR_BIT_SW];
    end

    // Reset sequencing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg        <= RCR_HOLD;
            hold_reg         <= HW'(HOLD_CYCLES - 1);
            cause_reg        <= RCR_FLAGS_POR;
            system_reset_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                RCR_RUN: begin
                    if (|req) begin
                        state_reg        <= RCR_HOLD;
                        hold_reg         <= HW'(HOLD_CYCLES - 1);
                        cause_reg        <= pick_cause(req);
                        system_reset_reg <= 1'b1;
                    end
                end
                RCR_HOLD: begin
                    if (level_hold) begin
                        hold_reg <= HW'(HOLD_CYCLES - 1);
                    end else if (hold_reg == '0) begin
                        state_reg        <= RCR_RUN;
                        system_reset_reg <= 1'b0;
                    end else begin
                        hold_reg <= hold_reg - HW'(1);
                    end
                end
            endcase
        end
    end

    // Cause flags are replaced as a whole when reset ends
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_reg <= RCR_FLAGS_POR;
        end else if (hold_done) begin
            flags_reg <= cause_reg;
        end
    end

    // Writable enables; read-only and force bits are not stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst || hold_done) begin
            enables_reg <= RCR_ENABLES_RST;
        end else if (cause_write) begin
            enables_reg[RCR_BIT_USB] <= sfr_wdata[RCR_BIT_USB];
            enables_reg[RCR_BIT_CMP] <= sfr_wdata[RCR_BIT_CMP];
            enables_reg[RCR_BIT_MCD] <= sfr_wdata[RCR_BIT_MCD];
            enables_reg[RCR_BIT_POR] <= sfr_wdata[RCR_BIT_POR];
        end
    end

    // Reads return flags only, so read-modify-write would corrupt enables
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sfr_rdata_reg <= 8'h00;
        end else if (sfr_rd && (sfr_addr == RCR_CAUSE_ADDR) && (state_reg == RCR_RUN)) begin
            sfr_rdata_reg <= flags_reg;
        end else begin
            sfr_rdata_reg <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            vbus_last_reg <= 1'b0;
        end else begin
            vbus_last_reg <= vbus_level;
        end
    end

    // Watchdog restarts enabled after every reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst || hold_done) begin
            wdt_run_reg <= 1'b1;
        end else if (wdt_stop) begin
            wdt_run_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !wdt_run_reg || state_reg == RCR_HOLD) begin
            wdt_pre_reg <= '0;
            wdt_cnt_reg <= '0;
            wdt_ovf_reg <= 1'b0;
        end else begin
            wdt_ovf_reg <= 1'b0;
            if (wdt_pre_reg == PW'(WDT_PRESCALE - 1)) begin
                wdt_pre_reg <= '0;
            end else begin
                wdt_pre_reg <= wdt_pre_reg + PW'(1);
            end
            if (wdt_kick) begin
                wdt_cnt_reg <= '0;
            end else if (wdt_pre_reg == PW'(WDT_PRESCALE - 1)) begin
                if (wdt_cnt_reg == WW'(WDT_TICKS - 1)) begin
                    wdt_cnt_reg <= '0;
                    wdt_ovf_reg <= 1'b1;
                end else begin
                    wdt_cnt_reg <= wdt_cnt_reg + WW'(1);
                end
            end
        end
    end

    rcr_clock_loss #(
        .TIMEOUT_CYCLES (CLOCK_LOSS_CYCLES)
    ) u_clock_loss (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .enable       (enables_reg[RCR_BIT_MCD] && (state_reg == RCR_RUN)),
        .clk_activity (clk_activity),
        .timeout      (clock_lost)
    );

    assign sfr_rdata    = sfr_rdata_reg;
    assign system_reset = system_reset_reg;
    assign wdt_running  = wdt_run_reg;

endmodule
`default_nettype wire

// ===== dv/rcr_chk.sv
// Checker for the reset cause recorder, watching only its top-level ports.
// Assumes one clock domain and the synchronous active-high sys_rst.
`timescale 1ns/100ps
`default_nettype none
module rcr_chk
    import rcr_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Sources and results
    input wire logic       pin_rst_n,
    input wire logic       mem_fault,
    input wire logic       system_reset,
    input wire logic       wdt_running
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_read;
        sfr_rd && sfr_addr == RCR_CAUSE_ADDR && !system_reset;
    endsequence
    sequence s_sw_write;
        sfr_wr && sfr_addr == RCR_CAUSE_ADDR && sfr_wdata[RCR_BIT_SW] && !system_reset;
    endsequence

    a_read_idle: assert property (!(sfr_rd && sfr_addr == RCR_CAUSE_ADDR) |=> sfr_rdata == 8'h00)
        else $error("read data without a read");
    a_one_cause: assert property (s_read |=> $onehot(sfr_rdata))
        else $error("cause flags not one-hot");
    a_sw_force: assert property (s_sw_write |=> system_reset [*4])
        else $error("software write did not force reset");
    a_pin_reset: assert property (!pin_rst_n |=> system_reset)
        else $error("pin low without reset");
    a_mem_reset: assert property (mem_fault && !system_reset |=> system_reset)
        else $error("memory fault without reset");
    a_hold_min: assert property ($rose(system_reset) |-> system_reset [*4])
        else $error("reset released too early");
    a_wdt_on_exit: assert property ($fell(system_reset) |-> wdt_running)
        else $error("watchdog off after reset");
    a_quiet_rst: assert property (system_reset |=> sfr_rdata == 8'h00)
        else $error("read data during reset");
endmodule

bind rcr_reset_cause_recorder rcr_chk i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_rst_n(pin_rst_n), .mem_fault(mem_fault),
    .system_reset(system_reset), .wdt_running(wdt_running));
`default_nettype wire

// ===== dv/tb.sv
// Testbench: drives every reset source in turn and reads back the cause flags.
// Assumes shortened hold and watchdog counts (4 and 4) on the recorder.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rcr_pkg::*;
    logic       clk_sys = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, pin_rst_n = 1, cmp_above = 1;
    logic       vdd_above = 1, clk_activity = 0, usb_bus_reset = 0, vbus_level = 0, vbus_pol_rising = 1;
    logic       mem_fault = 0, wdt_kick = 0, wdt_stop = 0, kick_en = 1, freeze = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    wire logic [7:0] sfr_rdata;
    wire logic  system_reset, wdt_running;
    int         fails = 0, tests_run = 0, cyc = 0;
    int         en_tab[10]   = '{8'h10, 8'h00, 8'h80, 8'h80, 8'h20, 8'h04, 8'h02, 8'h00, 8'h00, 8'h80};
    int         flag_tab[10] = '{8'h10, 8'h40, 8'h80, 8'h80, 8'h20, 8'h04, 8'h02, 8'h08, 8'h01, 8'h80};

    rcr_reset_cause_recorder #(.HOLD_CYCLES(4), .WDT_TICKS(4)) i_rcr_reset_cause_recorder (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_rst_n(pin_rst_n), .cmp_above(cmp_above),
        .vdd_above(vdd_above), .clk_activity(clk_activity), .usb_bus_reset(usb_bus_reset),
        .vbus_level(vbus_level), .vbus_pol_rising(vbus_pol_rising), .mem_fault(mem_fault),
        .wdt_kick(wdt_kick), .wdt_stop(wdt_stop), .system_reset(system_reset), .wdt_running(wdt_running));

    always #12.5 clk_sys = ~clk_sys;
    // Kicks every 16 cycles, well inside the 48-cycle watchdog span
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        wdt_kick <= kick_en && (cyc % 16 == 0);
        clk_activity <= freeze ? clk_activity : ~clk_activity;
    end

    task automatic chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        // Read data stands only until the next edge
        @(negedge clk_sys);
        chk(sfr_rdata, exp);
    endtask
    task automatic wait_run();
        for (int n = 0; n < 400 && system_reset !== 1'b0; n++) @(negedge clk_sys);
        chk({7'h00, system_reset}, 8'h00);
    endtask
    task automatic trial(int k);
        if (k == 9) begin
            // Falling polarity; the rising edge while USB is disabled must not reset
            @(posedge clk_sys);
            {vbus_pol_rising, vbus_level} <= 2'b01;
        end
        wr(RCR_CAUSE_ADDR, 8'(en_tab[k]) | (8'($urandom) & 8'h49));
        case (k)
            1: mem_fault <= 1'b1;
            2: usb_bus_reset <= 1'b1;
            3: vbus_level <= 1'b1;
            4: cmp_above <= 1'b0;
            5: freeze <= 1'b1;
            6: vdd_above <= 1'b0;
            7: kick_en <= 1'b0;
            8: pin_rst_n <= 1'b0;
            9: vbus_level <= 1'b0;
            default: ;
        endcase
        for (int n = 0; n < 200 && system_reset !== 1'b1; n++) @(negedge clk_sys);
        chk({7'h00, system_reset}, 8'h01);
        @(posedge clk_sys);
        {mem_fault, usb_bus_reset, vbus_level, freeze} <= 4'h0;
        {cmp_above, vdd_above, kick_en, pin_rst_n} <= 4'hF;
        wait_run();
        chk({7'h00, wdt_running}, 8'h01);
        rd(RCR_CAUSE_ADDR, 8'(flag_tab[k]));
        $display("test %0d done", k);
    endtask
    task automatic test_done();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100us;
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(84026));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wait_run();
        rd(RCR_CAUSE_ADDR, 8'h02);
        // Sources stay disabled after reset, so these lows must not reset
        @(posedge clk_sys);
        {cmp_above, vdd_above, freeze} <= 3'b001;
        wr(8'($urandom_range(0, 8'hEE)), 8'h10);
        repeat (30) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({7'h00, system_reset}, 8'h00);
        @(posedge clk_sys);
        {cmp_above, vdd_above, freeze} <= 3'b110;
        rd(8'($urandom_range(0, 8'hEE)), 8'h00);
        $display("test disabled sources done");
        for (int k = 0; k < 10; k++) trial(k);
        // A stopped watchdog must not fire without kicks
        @(posedge clk_sys);
        {wdt_stop, kick_en} <= 2'b10;
        @(posedge clk_sys);
        wdt_stop <= 1'b0;
        repeat (100) @(posedge clk_sys);
        kick_en <= 1'b1;
        @(negedge clk_sys);
        chk({6'h00, wdt_running, system_reset}, 8'h00);
        $display("test watchdog stop done");
        // Second power-on reset in mid-run
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wait_run();
        chk({7'h00, wdt_running}, 8'h01);
        rd(RCR_CAUSE_ADDR, 8'h02);
        $display("test mid-run reset done");
        test_done();
    end
endmodule
`default_nettype wire
